/* File: verilog/pd_sink_pkg.sv */
// shared constants and types for the sink port policy link
// What this block does
// - attach on vbus safe5v, then await offers
// - no offers in wait time: send hard reset
// - never send cable packets unless vconn source
// - acknowledge offers with goodcrc, connection made
// - request, accept, ready gives explicit contract
// - in ready state handle and answer messages
// - new power needs send a new request
// - request selecting no offer is an error
// - unusable offers: request anyway, flag mismatch, led
// - rd termination always asserted as sink
// - power swap makes port source, stays in ready
// - data swap flips dfp/ufp, a received one also exits modes
// - vconn swap make before break, roles kept
// - cable talk only idle, sop ends it
// - dfp sink may send vdms for modes
// - vbus loss ends connection unless expected or port is source
// - missing goodcrc: soft reset within limit
// - soft reset fails or power error: hard reset
// - soft reset keeps power, roles, modes
// - hard reset: default power, ufp, vconn back
// - after hard reset retry twice then wait
// - no answer to retries enters error path
package pd_sink_pkg;

	localparam int unsigned clk_mhz = 250;
	// timeouts in microseconds, defaults only
	localparam int unsigned wait_cap_us   = 500;
	localparam int unsigned receive_us    = 1;
	localparam int unsigned soft_reset_us = 15;
	localparam int unsigned hard_reset_us = 5;
	localparam int unsigned wait_cap_cyc   = wait_cap_us * clk_mhz;
	localparam int unsigned receive_cyc    = receive_us * clk_mhz;
	localparam int unsigned soft_reset_cyc = soft_reset_us * clk_mhz;
	localparam int unsigned hard_reset_cyc = hard_reset_us * clk_mhz;
	localparam int unsigned hard_retry_max = 2;
	localparam int unsigned cnt_w          = 24;

	typedef enum logic [3:0] {
		msg_none       = 4'h0,
		msg_src_caps   = 4'h1,
		msg_request    = 4'h2,
		msg_accept     = 4'h3,
		msg_reject     = 4'h4,
		msg_ps_rdy     = 4'h5,
		msg_soft_reset = 4'h6,
		msg_pr_swap    = 4'h7,
		msg_dr_swap    = 4'h8,
		msg_vc_swap    = 4'h9,
		msg_vdm        = 4'ha,
		msg_good_crc   = 4'hb
	} msg_e;

	typedef enum logic [1:0] {
		sop_main   = 2'h0,
		sop_prime  = 2'h1,
		sop_dprime = 2'h2
	} sop_e;

	typedef logic [cnt_w-1:0] cnt_t;

	function automatic logic expired(input cnt_t c, input int unsigned lim);
		expired = (c >= cnt_t'(lim));
	endfunction

endpackage

/* File: verilog/pd_link_if.sv */
// message link between sink policy and source partner
`timescale 1ns/100ps
interface pd_link_if;
	logic       snk_valid;
	logic [3:0] snk_msg;
	logic [1:0] snk_sop;
	logic [2:0] snk_obj;
	logic       snk_mismatch;
	logic       snk_hard_reset;
	logic       src_valid;
	logic [3:0] src_msg;
	logic [1:0] src_sop;
	logic       src_hard_reset;
	logic       vbus_5v;
	logic       vbus_0v;
	logic       rd_on;
	logic       snk_vconn;
	logic       src_vconn;

	modport sink (
		output snk_valid, snk_msg, snk_sop, snk_obj, snk_mismatch,
		output snk_hard_reset, rd_on, snk_vconn,
		input  src_valid, src_msg, src_sop, src_hard_reset,
		input  vbus_5v, vbus_0v, src_vconn
	);
	modport source (
		input  snk_valid, snk_msg, snk_sop, snk_obj, snk_mismatch,
		input  snk_hard_reset, rd_on, snk_vconn,
		output src_valid, src_msg, src_sop, src_hard_reset,
		output vbus_5v, vbus_0v, src_vconn
	);
endinterface

/* File: verilog/pd_timer.sv */
// restartable cycle counter with terminal flag
`timescale 1ns/100ps
module pd_timer
	import pd_sink_pkg::*;
#(
	parameter int unsigned limit = 16
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic nrst,
	// control
	input  wire logic restart,
	input  wire logic run,
	// status
	output logic      done
);
	typedef struct packed {
		cnt_t cnt;
	} timer_s;
	timer_s st_reg;
	timer_s st_next;

	always_comb begin
		st_next = st_reg;
		if (restart) begin
			st_next.cnt = '0;
		end else if (run && !expired(st_reg.cnt, limit)) begin
			st_next.cnt = st_reg.cnt + cnt_t'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign done = run && expired(st_reg.cnt, limit);
endmodule

/* File: verilog/pd_sink_end.sv */
// sink port policy engine
`timescale 1ns/100ps
module pd_sink_end
	import pd_sink_pkg::*;
#(
	parameter int unsigned wait_cap_lim = wait_cap_cyc,
	parameter int unsigned receive_lim  = receive_cyc,
	parameter int unsigned soft_lim     = soft_reset_cyc,
	parameter int unsigned hard_lim     = hard_reset_cyc
) (
	// clock and reset
	input  wire logic  clock,
	input  wire logic  nrst,
	// link
	pd_link_if.sink    link,
	// local policy
	input  wire logic       drp_en,
	input  wire logic       drd_en,
	input  wire logic       want_request,
	input  wire logic [2:0] want_obj,
	input  wire logic [2:0] offer_cnt,
	input  wire logic       cap_ok,
	input  wire logic       want_pr_swap,
	input  wire logic       want_dr_swap,
	input  wire logic       want_vc_swap,
	input  wire logic       want_cable,
	input  wire logic       want_vdm,
	input  wire logic       power_error,
	// status
	output logic       contract,
	output logic       connected,
	output logic       is_source,
	output logic       is_dfp,
	output logic       vconn_src,
	output logic       mode_active,
	output logic       fail_led,
	output logic       error_path
);
	typedef enum logic [8:0] {
		s_detached = 9'h001,
		s_wait_cap = 9'h002,
		s_request  = 9'h004,
		s_accept   = 9'h008,
		s_ps_rdy   = 9'h010,
		s_ready    = 9'h020,
		s_soft     = 9'h040,
		s_hard     = 9'h080,
		s_error    = 9'h100
	} state_e;

	typedef struct packed {
		state_e     state;
		logic       valid;
		logic [3:0] msg;
		logic [1:0] sop;
		logic [2:0] obj;
		logic       mism;
		logic       hard;
		logic       wait_ack;
		logic       cable;
		logic       swap_pend;
		logic       contract;
		logic       connected;
		logic       source;
		logic       dfp;
		logic       vconn;
		logic       vconn_both;
		logic       mode;
		logic       led;
		logic [1:0] hard_cnt;
		logic       expect_drop;
	} sink_s;
	sink_s st_reg;
	sink_s st_next;

	logic t_cap_rst, t_ack_rst, t_cap_done, t_ack_done;
	logic t_soft_done, t_hard_done;
	logic rx;

	assign rx = link.src_valid && (link.src_sop == sop_main);
	assign t_cap_rst = (st_reg.state != s_wait_cap);
	assign t_ack_rst = !st_reg.wait_ack;

	pd_timer #(.limit(wait_cap_lim)) u_cap (
		.clock(clock), .nrst(nrst), .restart(t_cap_rst),
		.run(1'b1), .done(t_cap_done));
	pd_timer #(.limit(receive_lim)) u_ack (
		.clock(clock), .nrst(nrst), .restart(t_ack_rst),
		.run(1'b1), .done(t_ack_done));
	pd_timer #(.limit(receive_lim + soft_lim)) u_soft (
		.clock(clock), .nrst(nrst), .restart(t_ack_rst),
		.run(1'b1), .done(t_soft_done));
	pd_timer #(.limit(receive_lim + hard_lim)) u_hard (
		.clock(clock), .nrst(nrst), .restart(t_ack_rst),
		.run(1'b1), .done(t_hard_done));

	// one message send, arms the goodcrc wait unless it sends goodcrc
	function automatic sink_s send(input sink_s s, input msg_e m);
		sink_s r;
		r = s;
		r.valid = 1'b1;
		r.msg = m;
		r.sop = sop_main;
		r.wait_ack = (m != msg_good_crc);
		r.cable = 1'b0;
		return r;
	endfunction

	function automatic sink_s hard_reset(input sink_s s);
		sink_s r;
		r = s;
		r.hard = 1'b1;
		r.state = s_hard;
		r.contract = 1'b0;
		r.source = 1'b0;
		r.dfp = 1'b0;
		r.vconn = 1'b0;
		r.vconn_both = 1'b0;
		r.mode = 1'b0;
		r.wait_ack = 1'b0;
		r.expect_drop = 1'b1;
		return r;
	endfunction

	always_comb begin
		st_next = st_reg;
		st_next.valid = 1'b0;
		st_next.hard = 1'b0;
		// partner replies without goodcrc, a reply also proves delivery
		if (rx && link.src_msg != msg_src_caps) begin
			st_next.wait_ack = 1'b0;
		end
		if (st_reg.state == s_detached) begin
			if (link.vbus_5v) begin
				st_next.state = s_wait_cap;
				st_next.hard_cnt = 2'h0;
			end
		end else if (link.vbus_0v && !st_reg.expect_drop && !st_reg.source) begin
			st_next = '0;
			st_next.state = s_detached;
		end else if (power_error && st_reg.state != s_hard) begin
			st_next = hard_reset(st_reg);
		end else if (link.src_hard_reset) begin
			st_next = hard_reset(st_reg);
			st_next.hard = 1'b0;
		end else if (rx && link.src_msg == msg_soft_reset) begin
			st_next = send(st_reg, msg_accept);
			st_next.wait_ack = 1'b0;
			st_next.state = s_wait_cap;
		end else if (st_reg.wait_ack && t_hard_done) begin
			st_next = hard_reset(st_reg);
		end else if (st_reg.wait_ack && t_ack_done && st_reg.state != s_soft) begin
			st_next = send(st_reg, msg_soft_reset);
			st_next.state = s_soft;
			st_next.wait_ack = st_reg.wait_ack;
		end else begin
			case (st_reg.state)
			s_wait_cap: begin
				if (rx && link.src_msg == msg_src_caps) begin
					st_next = send(st_reg, msg_good_crc);
					st_next.connected = 1'b1;
					st_next.hard_cnt = 2'h0;
					st_next.state = s_request;
				end else if (t_cap_done) begin
					// first hard reset plus the retries, then give up
					if (st_reg.hard_cnt > 2'(hard_retry_max)) begin
						st_next.state = s_error;
					end else begin
						st_next = hard_reset(st_reg);
						st_next.hard_cnt = st_reg.hard_cnt + 2'h1;
					end
				end
			end
			s_request: begin
				st_next = send(st_reg, msg_request);
				// a request must always name an offer
				st_next.obj = (want_obj < offer_cnt && want_obj != 3'h0)
					? want_obj : 3'h1;
				st_next.mism = !cap_ok;
				st_next.led = !cap_ok;
				st_next.state = s_accept;
			end
			s_accept: begin
				if (rx && link.src_msg == msg_accept) begin
					st_next.state = s_ps_rdy;
					st_next.expect_drop = 1'b1;
				end else if (rx && link.src_msg == msg_reject) begin
					st_next.state = st_reg.contract ? s_ready : s_wait_cap;
				end
			end
			s_ps_rdy: begin
				if (rx && link.src_msg == msg_ps_rdy) begin
					st_next.contract = 1'b1;
					st_next.expect_drop = 1'b0;
					st_next.state = s_ready;
				end
			end
			s_soft: begin
				if (rx && link.src_msg == msg_accept) begin
					st_next.wait_ack = 1'b0;
					st_next.state = s_wait_cap;
				end
			end
			s_hard: begin
				st_next.state = s_wait_cap;
				st_next.expect_drop = 1'b0;
			end
			s_ready: begin
				if (rx) begin
					st_next.cable = 1'b0;
					case (link.src_msg)
					msg_src_caps: begin
						st_next = send(st_reg, msg_good_crc);
						st_next.state = s_request;
					end
					msg_pr_swap: begin
						st_next = send(st_reg, drp_en ? msg_accept : msg_reject);
						st_next.source = st_reg.source ^ drp_en;
					end
					msg_dr_swap: begin
						st_next = send(st_reg, drd_en ? msg_accept : msg_reject);
						st_next.dfp = st_reg.dfp ^ drd_en;
						st_next.mode = 1'b0;
					end
					msg_vc_swap: begin
						st_next = send(st_reg, msg_accept);
						st_next.vconn_both = 1'b1;
					end
					default: begin
					end
					endcase
				end else if (st_reg.vconn_both && link.src_vconn == st_reg.vconn) begin
					// swap completes once the partner caught up
					st_next.vconn = !st_reg.vconn;
					st_next.vconn_both = 1'b0;
				end else if (st_reg.swap_pend) begin
					st_next.swap_pend = 1'b0;
				end else if (!st_reg.wait_ack) begin
					if (want_request) begin
						st_next.state = s_request;
					end else if (want_pr_swap && drp_en) begin
						st_next = send(st_reg, msg_pr_swap);
						st_next.source = !st_reg.source;
						st_next.expect_drop = 1'b1;
					end else if (want_dr_swap && drd_en) begin
						st_next = send(st_reg, msg_dr_swap);
						st_next.dfp = !st_reg.dfp;
					end else if (want_vc_swap) begin
						st_next = send(st_reg, msg_vc_swap);
						st_next.vconn_both = 1'b1;
					end else if (want_vdm && st_reg.dfp) begin
						st_next = send(st_reg, msg_vdm);
						st_next.mode = !st_reg.mode;
					end else if (want_cable && st_reg.vconn && !st_reg.cable) begin
						st_next.valid = 1'b1;
						st_next.msg = msg_vdm;
						st_next.sop = sop_prime;
						st_next.cable = 1'b1;
					end else begin
						st_next.cable = 1'b0;
					end
				end
			end
			s_error: begin
				st_next.connected = 1'b0;
			end
			default: begin
				st_next.state = s_detached;
			end
			endcase
		end
		if (st_next.sop != sop_main && !st_next.vconn) begin
			st_next.valid = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			st_reg <= '0;
			st_reg.state <= s_detached;
		end else begin
			st_reg <= st_next;
		end
	end

	assign link.snk_valid = st_reg.valid;
	assign link.snk_msg = st_reg.msg;
	assign link.snk_sop = st_reg.sop;
	assign link.snk_obj = st_reg.obj;
	assign link.snk_mismatch = st_reg.mism;
	assign link.snk_hard_reset = st_reg.hard;
	assign link.rd_on = !st_reg.source;
	assign link.snk_vconn = st_reg.vconn | st_reg.vconn_both;
	assign contract = st_reg.contract;
	assign connected = st_reg.connected;
	assign is_source = st_reg.source;
	assign is_dfp = st_reg.dfp;
	assign vconn_src = st_reg.vconn;
	assign mode_active = st_reg.mode;
	assign fail_led = st_reg.led;
	assign error_path = (st_reg.state == s_error);
endmodule

/* File: verilog/pd_source_end.sv */
// source partner policy, minimal offer and contract logic
`timescale 1ns/100ps
module pd_source_end
	import pd_sink_pkg::*;
(
	// clock and reset
	input  wire logic  clock,
	input  wire logic  nrst,
	// link
	pd_link_if.source  link,
	// user side
	input  wire logic       attach,
	input  wire logic       send_caps,
	input  wire logic [2:0] offer_cnt,
	input  wire logic       supply_ready,
	output logic            contract,
	output logic            req_error
);
	typedef struct packed {
		logic       valid;
		logic [3:0] msg;
		logic       pend_rdy;
		logic       contract;
		logic       err;
		logic       vconn;
	} src_s;
	src_s st_reg;
	src_s st_next;

	always_comb begin
		st_next = st_reg;
		st_next.valid = 1'b0;
		if (link.snk_hard_reset) begin
			st_next = '0;
			st_next.vconn = 1'b1;
		end else if (link.snk_valid && link.snk_sop == sop_main) begin
			case (link.snk_msg)
			msg_request: begin
				st_next.valid = 1'b1;
				if (link.snk_obj == 3'h0 || link.snk_obj >= offer_cnt) begin
					st_next.msg = msg_reject;
					st_next.err = 1'b1;
				end else begin
					st_next.msg = msg_accept;
					st_next.pend_rdy = 1'b1;
				end
			end
			msg_soft_reset: begin
				st_next.valid = 1'b1;
				st_next.msg = msg_accept;
				st_next.pend_rdy = 1'b0;
			end
			msg_vc_swap: begin
				st_next.valid = 1'b1;
				st_next.msg = msg_accept;
				st_next.vconn = !st_reg.vconn;
			end
			default: begin
				st_next.valid = (link.snk_msg != msg_good_crc);
				st_next.msg = msg_good_crc;
			end
			endcase
		end else if (st_reg.pend_rdy && supply_ready) begin
			st_next.valid = 1'b1;
			st_next.msg = msg_ps_rdy;
			st_next.pend_rdy = 1'b0;
			st_next.contract = 1'b1;
		end else if (send_caps && attach) begin
			st_next.valid = 1'b1;
			st_next.msg = msg_src_caps;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			st_reg <= '0;
			st_reg.vconn <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign link.src_valid = st_reg.valid;
	assign link.src_msg = st_reg.msg;
	assign link.src_sop = sop_main;
	assign link.src_hard_reset = 1'b0;
	assign link.vbus_5v = attach;
	assign link.vbus_0v = !attach;
	assign link.src_vconn = st_reg.vconn;
	assign contract = st_reg.contract;
	assign req_error = st_reg.err;
endmodule

/* File: verif/pd_sink_checker.sv */
// concurrent checks on the link between sink and source ends
`timescale 1ns/100ps
module pd_sink_checker
	import pd_sink_pkg::*;
#(
	parameter int unsigned wait_lim = 20,
	parameter int unsigned hard_lim = 8
) (
	// clock and reset
	input wire logic       clock,
	input wire logic       nrst,
	// sink side
	input wire logic       snk_valid,
	input wire logic [3:0] snk_msg,
	input wire logic [1:0] snk_sop,
	input wire logic [2:0] snk_obj,
	input wire logic       snk_hard_reset,
	input wire logic       rd_on,
	input wire logic       snk_vconn,
	// source side
	input wire logic       src_valid,
	input wire logic [3:0] src_msg,
	input wire logic [1:0] src_sop,
	input wire logic       src_vconn,
	input wire logic       vbus_5v
);
	// slack covers attach sampling and the hard reset pause
	localparam int unsigned wait_max = wait_lim + hard_lim + 4;

	logic [15:0] wcnt;
	logic        got_caps;
	logic [1:0]  hr_n;
	wire logic   caps_in = src_valid && src_msg == msg_src_caps
		&& src_sop == sop_main;

	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	always_ff @(posedge clock) begin
		if (!nrst || !vbus_5v) begin
			wcnt     <= 16'h0;
			got_caps <= 1'b0;
			hr_n     <= 2'h0;
		end else begin
			if (caps_in) begin
				got_caps <= 1'b1;
				hr_n     <= 2'h0;
			end else if (snk_hard_reset) begin
				got_caps <= 1'b0;
				if (hr_n != 2'h3) begin
					hr_n <= hr_n + 2'h1;
				end
			end
			// stops counting once retries are spent
			if (caps_in || snk_hard_reset || got_caps || hr_n == 2'h3) begin
				wcnt <= 16'h0;
			end else begin
				wcnt <= wcnt + 16'h1;
			end
		end
	end

	sequence s_caps;
		src_valid && src_msg == msg_src_caps && src_sop == sop_main;
	endsequence
	sequence s_ack;
		snk_valid && snk_msg == msg_good_crc;
	endsequence
	sequence s_req;
		snk_valid && snk_msg == msg_request;
	endsequence

	property p_rd_on;
		rd_on;
	endproperty
	property p_goodcrc;
		s_caps |=> s_ack;
	endproperty
	property p_request;
		s_caps ##1 s_ack |=> s_req;
	endproperty
	property p_answer;
		s_req |=> src_valid && (src_msg == msg_accept
			|| src_msg == msg_reject);
	endproperty
	property p_no_cable;
		snk_valid && !snk_vconn |-> snk_sop == sop_main;
	endproperty
	property p_req_obj;
		s_req |-> snk_obj != 3'h0;
	endproperty
	property p_wait_bound;
		wcnt <= 16'(wait_max);
	endproperty
	property p_hr_limit;
		snk_hard_reset |-> hr_n != 2'h3;
	endproperty
	property p_vconn_mbb;
		$fell(src_vconn) |-> snk_vconn;
	endproperty

	a_rd_on: assert property (p_rd_on)
		else $error("rd termination dropped");
	a_goodcrc: assert property (p_goodcrc)
		else $error("offers not acknowledged");
	a_request: assert property (p_request)
		else $error("no request after acknowledge");
	a_answer: assert property (p_answer)
		else $error("request not answered");
	a_no_cable: assert property (p_no_cable)
		else $error("cable packet without vconn");
	a_req_obj: assert property (p_req_obj)
		else $error("request selects no offer");
	a_wait_bound: assert property (p_wait_bound)
		else $error("no hard reset after wait time");
	a_hr_limit: assert property (p_hr_limit)
		else $error("too many hard resets");
	a_vconn_mbb: assert property (p_vconn_mbb)
		else $error("vconn broken before made");
endmodule

/* File: verif/pd_sink_port_policy_tb.sv */
// self-checking bench joining sink and source ends
`timescale 1ns/100ps
module pd_sink_port_policy_tb
	import pd_sink_pkg::*;
;
	typedef struct packed {
		logic [4:0] exp;
		logic [4:0] mask;
	} note_s;
	localparam int unsigned wait_l = 20;
	localparam int unsigned hard_l = 8;

	logic        clock, nrst, attach, send_caps, supply_ready, cap_ok;
	logic        want_request, want_cable, want_vdm, want_vc_swap;
	logic        drd_en, want_dr_swap;
	logic        power_error, src_contract;
	logic [2:0]  want_obj, offer_cnt;
	logic [4:0]  st, st_d;
	logic [31:0] seed;
	int          n_errors, compares, hr, cyc;
	note_s       q[$];
	note_s       n;

	pd_link_if link();

	pd_sink_end #(.wait_cap_lim(wait_l), .receive_lim(4), .soft_lim(4),
		.hard_lim(hard_l)) i_pd_sink_end (
		.clock(clock), .nrst(nrst), .link(link),
		.drp_en(1'b0), .drd_en(drd_en), .want_request(want_request),
		.want_obj(want_obj), .offer_cnt(offer_cnt), .cap_ok(cap_ok),
		.want_pr_swap(1'b0), .want_dr_swap(want_dr_swap),
		.want_vc_swap(want_vc_swap), .want_cable(want_cable),
		.want_vdm(want_vdm), .power_error(power_error),
		.contract(st[4]), .connected(st[3]), .is_source(),
		.is_dfp(st[1]), .vconn_src(), .mode_active(),
		.fail_led(st[2]), .error_path(st[0]));

	pd_source_end i_pd_source_end (
		.clock(clock), .nrst(nrst), .link(link), .attach(attach),
		.send_caps(send_caps), .offer_cnt(offer_cnt),
		.supply_ready(supply_ready), .contract(src_contract),
		.req_error());

	pd_sink_checker #(.wait_lim(wait_l), .hard_lim(hard_l))
		i_pd_sink_checker (
		.clock(clock), .nrst(nrst), .snk_valid(link.snk_valid),
		.snk_msg(link.snk_msg), .snk_sop(link.snk_sop),
		.snk_obj(link.snk_obj), .snk_hard_reset(link.snk_hard_reset),
		.rd_on(link.rd_on), .snk_vconn(link.snk_vconn),
		.src_valid(link.src_valid), .src_msg(link.src_msg),
		.src_sop(link.src_sop), .src_vconn(link.src_vconn),
		.vbus_5v(link.vbus_5v));

	function automatic logic [31:0] rnd(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction

	task automatic step(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask

	task automatic cmp(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic test_done;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic do_reset;
		nrst = 1'b0;
		attach = 1'b0;
		step(2);
		nrst = 1'b1;
		hr = 0;
	endtask

	// offers then request, accept and ready
	task automatic connect;
		send_caps = 1'b1;
		supply_ready = 1'b1;
		q.push_back(note_s'{{2'b11, !cap_ok, 2'b00}, 5'h1f});
		attach = 1'b1;
		step(1);
		// one offer only, repeated offers restart the negotiation
		send_caps = 1'b0;
		step(99);
		cmp("pending", 0, 8'(q.size()));
	endtask

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// results: contract up, error path up, connection lost
	always @(posedge clock) begin
		st_d <= st;
		if (link.snk_hard_reset === 1'b1) hr++;
		if (nrst && ((st[4] && !st_d[4]) || (st[0] && !st_d[0])
			|| (!st[3] && st_d[3]))) begin
			if (q.size() == 0) begin
				cmp("note", 8'h1, 8'h0);
			end else begin
				n = q.pop_front();
				cmp("status", 8'(n.exp & n.mask), 8'(st & n.mask));
			end
		end
	end

	// bound far above the length of the whole run
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			test_done;
		end
	end

	initial begin
		{nrst, attach, send_caps, supply_ready, power_error} = 5'h0;
		{want_request, want_cable, want_vdm, want_vc_swap} = 4'h0;
		{drd_en, want_dr_swap} = 2'h0;
		cap_ok = 1'b1;
		want_obj = 3'h1;
		offer_cnt = 3'h2;
		seed = 32'he51f4def;
		{n_errors, compares, hr, cyc} = {32'h0, 32'h0, 32'h0, 32'h0};
		do_reset;
		// silent source: hard reset, two retries, then error path
		q.push_back(note_s'{5'h01, 5'h19});
		attach = 1'b1;
		step(400);
		cmp("pending", 0, 8'(q.size()));
		cmp("hard resets", 3, 8'(hr));
		for (int i = 0; i < 6; i++) begin
			do_reset;
			seed = rnd(seed);
			offer_cnt = 3'h2 + 3'(seed[2:0] % 6);
			// any index, also 0 or past the offers
			want_obj = seed[5:3];
			cap_ok = seed[6];
			want_cable = seed[7];
			want_vdm = seed[8];
			drd_en = seed[10];
			connect;
			cmp("source contract", 1, 8'(src_contract));
			want_request = 1'b1;
			step(1);
			want_request = 1'b0;
			step(30);
			cmp("contract kept", 1, 8'(st[4]));
			cmp("hard resets", 0, 8'(hr));
			want_dr_swap = 1'b1;
			step(1);
			want_dr_swap = 1'b0;
			step(3);
			cmp("data role", 8'(drd_en), 8'(st[1]));
			want_vc_swap = seed[9];
			step(30);
			want_vc_swap = 1'b0;
			q.push_back(note_s'{5'h00, 5'h1b});
			attach = 1'b0;
			step(20);
			cmp("pending", 0, 8'(q.size()));
		end
		// supply fault between accept and ready
		do_reset;
		send_caps = 1'b1;
		supply_ready = 1'b0;
		attach = 1'b1;
		step(1);
		send_caps = 1'b0;
		step(19);
		power_error = 1'b1;
		step(1);
		power_error = 1'b0;
		supply_ready = 1'b1;
		// source is reset by the hard reset, offers come a cycle later
		send_caps = 1'b1;
		q.push_back(note_s'{5'h18, 5'h1b});
		step(2);
		send_caps = 1'b0;
		step(198);
		cmp("hard resets", 1, 8'(hr));
		cmp("pending", 0, 8'(q.size()));
		test_done;
	end
endmodule
